// >>> common/atx_pkg.sv
/*
  shared constants of the async serial transmitter: register indices,
  field positions, write masks, reset values, baud scaling and bus codes.
  assumes: included first in compile order, used only as atx_pkg::name.
*/
package atx_pkg;
  // register indices on the device register port
  localparam logic [2:0] OFS_TX_STATUS_CONTROL = 3'h0;
  localparam logic [2:0] OFS_RX_STATUS_CONTROL = 3'h1;
  localparam logic [2:0] OFS_BAUD_CONTROL = 3'h2;
  localparam logic [2:0] OFS_BAUD_DIVISOR_LOW = 3'h3;
  localparam logic [2:0] OFS_BAUD_DIVISOR_HIGH = 3'h4;
  localparam logic [2:0] OFS_TRANSMIT_HOLDING = 3'h5;
  localparam logic [2:0] OFS_IRQ_ENABLE = 3'h6;
  localparam logic [2:0] OFS_IRQ_FLAG = 3'h7;
  // transmit_status_control fields
  localparam int TSC_NINE_BIT_TX = 6;
  localparam int TSC_TRANSMIT_ENABLE = 5;
  localparam int TSC_CLOCKED_MODE = 4;
  localparam int TSC_HIGH_SPEED = 2;
  localparam int TSC_SHIFT_EMPTY = 1;
  localparam int TSC_NINTH_BIT = 0;
  // receive_status_control, baud_control and irq fields
  localparam int RSC_SERIAL_PORT_ENABLE = 7;
  localparam int BDC_WIDE_DIVISOR = 3;
  localparam int IRQ_GLOBAL = 7;
  localparam int IRQ_PERIPHERAL = 6;
  localparam int IRQ_TX_EMPTY = 4;
  // writable bits; the rest are status or unimplemented
  localparam logic [7:0] TSC_WR_MASK = 8'hfd;
  localparam logic [7:0] RSC_WR_MASK = 8'hf9;
  localparam logic [7:0] BDC_WR_MASK = 8'h1b;
  localparam logic [7:0] IRQ_WR_MASK = 8'hd0;
  localparam logic [7:0] REG_RESET = 8'h00;
  // bit period = (divisor + 1) << shift system clocks
  localparam logic [2:0] BAUD_SHIFT_X64 = 3'h6;
  localparam logic [2:0] BAUD_SHIFT_X16 = 3'h4;
  localparam logic [2:0] BAUD_SHIFT_X4 = 3'h2;
  // bits after the start bit: data plus one stop
  localparam logic [3:0] FRAME_BITS_8 = 4'h9;
  localparam logic [3:0] FRAME_BITS_9 = 4'ha;
  // host side axi4-lite map
  localparam logic [5:0] HOST_STATUS_OFS = 6'h20;
  localparam logic [3:0] DEV_WINDOW_LAST = 4'h7;
  localparam int HOST_STAT_IRQ = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> common/atx_if.sv
/*
  register port between the controller and the transmitter.
  assumes: both ends on the same sys_clk; the bench ties the ends.
*/
`timescale 1ns/100ps
`default_nettype none
interface atx_if;
  logic [2:0] addr; // register index
  logic wr; // one-cycle write strobe
  logic [7:0] wdata; // write data
  logic [7:0] rdata; // read data of addr, combinational
  logic irq; // gated buffer-empty interrupt request
  modport dev (input addr, input wr, input wdata, output rdata, output irq);
  modport host (output addr, output wr, output wdata, input rdata, input irq);
endinterface
`default_nettype wire

// >>> core/atx_baud.sv
/*
  bit-period tick generator: one-cycle tick every (divisor+1)<<shift clocks.
  assumes: restart pulses when a frame starts so the first bit is whole.
*/
`timescale 1ns/100ps
`default_nettype none
module atx_baud #(
  parameter int CNT_W = 22
) (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [15:0] divisor, // divisor pair value
  input wire logic [2:0] mult_shift, // log2 of the clock multiplier
  input wire logic restart, // realign the bit period
  output logic tick // one pulse per bit period
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt; // cycles in the current bit
    logic tick; // registered tick
  } atx_baud_state_t;

  atx_baud_state_t q, d;
  logic [CNT_W-1:0] last; // final count of a bit

  // terminal count; the widest product still fits CNT_W
  always_comb begin
    last = CNT_W'((({{(CNT_W-16){1'b0}}, divisor} + CNT_W'(1)) << mult_shift) - CNT_W'(1));
    d = q;
    d.tick = 1'b0;
    if (restart) begin
      // start at one: the registered tick costs a cycle, so the first bit stays whole
      d.cnt = CNT_W'(1);
    end else if (q.cnt >= last) begin
      d.cnt = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + CNT_W'(1);
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;
endmodule
`default_nettype wire

// >>> core/atx_dev.sv
/*
  asynchronous serial transmitter: register file, one-deep holding register,
  shift register and frame sequencer driving the transmit pin.
  assumes: register port driven by atx_if host end on the same clock,
  one instruction cycle equals one sys_clk cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module atx_dev (
  input wire logic sys_clk, // system clock, 25 MHz
  input wire logic rst_n, // async reset, active low
  atx_if.dev bus, // register port
  output logic tx_clock_pin, // serial line out
  output logic tx_clock_pin_oe_n // pin output enable, low drives
);
  typedef enum logic {ATX_IDLE, ATX_SEND} atx_tx_state_t;

  typedef struct packed {
    logic [7:0] tsc; // transmit_status_control storage
    logic [7:0] rsc; // receive_status_control storage
    logic [7:0] bdc; // baud_control storage
    logic [7:0] div_lo; // baud_divisor_low
    logic [7:0] div_hi; // baud_divisor_high
    logic [7:0] irq_en; // interrupt enables
    logic [8:0] hold; // tx_holding_reg with ninth bit
    logic hold_full; // a character waits
    logic flag; // tx_buffer_empty_flag
    atx_tx_state_t st; // sequencer state
    logic [9:0] shift; // tx_shift_reg: data then stop
    logic [3:0] left; // bits still to send after current
    logic line; // level on the line
  } atx_dev_state_t;

  atx_dev_state_t q, d;
  logic tick; // one per bit period
  logic restart; // realign the baud counter
  logic run; // transmitter running in async mode
  logic wr_hold; // write into the holding register
  logic [2:0] mult; // baud multiplier shift
  logic [15:0] divisor; // effective divisor

  // masked register update
  function automatic logic [7:0] merge(logic [7:0] old, logic [7:0] val, logic [7:0] m);
    merge = (old & ~m) | (val & m);
  endfunction

  // put a character into the shift register and start its frame
  function automatic atx_dev_state_t load_char(atx_dev_state_t s, logic [8:0] ch);
    atx_dev_state_t r;
    r = s;
    r.st = ATX_SEND;
    r.line = 1'b0;
    if (s.tsc[atx_pkg::TSC_NINE_BIT_TX]) begin
      r.shift = {1'b1, ch};
      r.left = atx_pkg::FRAME_BITS_9;
    end else begin
      r.shift = {2'b11, ch[7:0]};
      r.left = atx_pkg::FRAME_BITS_8;
    end
    return r;
  endfunction

  // baud scaling from the speed bits
  always_comb begin
    if (q.bdc[atx_pkg::BDC_WIDE_DIVISOR]) begin
      divisor = {q.div_hi, q.div_lo};
      mult = q.tsc[atx_pkg::TSC_HIGH_SPEED] ? atx_pkg::BAUD_SHIFT_X4 : atx_pkg::BAUD_SHIFT_X16;
    end else begin
      divisor = {8'h00, q.div_lo};
      mult = q.tsc[atx_pkg::TSC_HIGH_SPEED] ? atx_pkg::BAUD_SHIFT_X16 : atx_pkg::BAUD_SHIFT_X64;
    end
  end

  // bit period generator, restarted on every load
  atx_baud u_baud (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .divisor(divisor),
    .mult_shift(mult),
    .restart(restart),
    .tick(tick)
  );

  // next state: register writes, holding register and sequencer
  always_comb begin
    d = q;
    restart = 1'b0;
    // async transmit needs both enables set and clocked mode clear
    run = q.rsc[atx_pkg::RSC_SERIAL_PORT_ENABLE] & q.tsc[atx_pkg::TSC_TRANSMIT_ENABLE]
      & ~q.tsc[atx_pkg::TSC_CLOCKED_MODE];
    wr_hold = bus.wr && (bus.addr == atx_pkg::OFS_TRANSMIT_HOLDING) && run;
    if (bus.wr) begin
      unique case (bus.addr)
        atx_pkg::OFS_TX_STATUS_CONTROL: d.tsc = merge(q.tsc, bus.wdata, atx_pkg::TSC_WR_MASK);
        atx_pkg::OFS_RX_STATUS_CONTROL: d.rsc = merge(q.rsc, bus.wdata, atx_pkg::RSC_WR_MASK);
        atx_pkg::OFS_BAUD_CONTROL: d.bdc = merge(q.bdc, bus.wdata, atx_pkg::BDC_WR_MASK);
        atx_pkg::OFS_BAUD_DIVISOR_LOW: d.div_lo = bus.wdata;
        atx_pkg::OFS_BAUD_DIVISOR_HIGH: d.div_hi = bus.wdata;
        atx_pkg::OFS_IRQ_ENABLE: d.irq_en = merge(q.irq_en, bus.wdata, atx_pkg::IRQ_WR_MASK);
        default: ; // holding handled below; flag register is read only
      endcase
    end
    unique case (q.st)
      ATX_IDLE: begin
        if (wr_hold) begin
          d = load_char(d, {q.tsc[atx_pkg::TSC_NINTH_BIT], bus.wdata});
          restart = 1'b1;
        end
      end
      ATX_SEND: begin
        if (wr_hold) begin
          d.hold = {q.tsc[atx_pkg::TSC_NINTH_BIT], bus.wdata};
          d.hold_full = 1'b1;
        end
        if (tick) begin
          if (q.left == 4'h0) begin
            // stop bit done: take a queued character in this same cycle
            if (q.hold_full) begin
              d = load_char(d, q.hold);
              // a write landing in this same cycle stays queued behind it
              d.hold_full = wr_hold;
              restart = 1'b1;
            end else if (wr_hold) begin
              // a write racing the stop bit goes straight out, never stranded
              d = load_char(d, {q.tsc[atx_pkg::TSC_NINTH_BIT], bus.wdata});
              d.hold_full = 1'b0;
              restart = 1'b1;
            end else begin
              d.st = ATX_IDLE;
              d.line = 1'b1;
            end
          end else begin
            d.line = q.shift[0];
            d.shift = {1'b1, q.shift[9:1]};
            d.left = q.left - 4'h1;
          end
        end
      end
    endcase
    // dropping the port enable flushes everything and idles the line
    if (!q.rsc[atx_pkg::RSC_SERIAL_PORT_ENABLE]) begin
      d.st = ATX_IDLE;
      d.hold_full = 1'b0;
      d.line = 1'b1;
    end
    // flag follows the holding register one cycle late, so a write queued behind a busy frame
    // shows in the flag from the second cycle after it; a write that loads the idle shift register never shows
    d.flag = q.tsc[atx_pkg::TSC_TRANSMIT_ENABLE] & ~q.hold_full;
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{tsc: atx_pkg::REG_RESET, rsc: atx_pkg::REG_RESET, bdc: atx_pkg::REG_RESET,
             div_lo: atx_pkg::REG_RESET, div_hi: atx_pkg::REG_RESET,
             irq_en: atx_pkg::REG_RESET, hold: 9'h000, hold_full: 1'b0, flag: 1'b0,
             st: ATX_IDLE, shift: 10'h3ff, left: 4'h0, line: 1'b1};
    end else begin
      q <= d;
    end
  end

  // read mux; the holding register reads zero
  always_comb begin
    unique case (bus.addr)
      atx_pkg::OFS_TX_STATUS_CONTROL: begin
        bus.rdata = q.tsc;
        bus.rdata[atx_pkg::TSC_SHIFT_EMPTY] = (q.st == ATX_IDLE);
      end
      atx_pkg::OFS_RX_STATUS_CONTROL: bus.rdata = q.rsc;
      atx_pkg::OFS_BAUD_CONTROL: bus.rdata = q.bdc;
      atx_pkg::OFS_BAUD_DIVISOR_LOW: bus.rdata = q.div_lo;
      atx_pkg::OFS_BAUD_DIVISOR_HIGH: bus.rdata = q.div_hi;
      atx_pkg::OFS_IRQ_ENABLE: bus.rdata = q.irq_en;
      atx_pkg::OFS_IRQ_FLAG: begin
        bus.rdata = 8'h00;
        bus.rdata[atx_pkg::IRQ_TX_EMPTY] = q.flag;
      end
      default: bus.rdata = 8'h00;
    endcase
  end

  // request is a pure gate of the flag
  assign bus.irq = q.flag & q.irq_en[atx_pkg::IRQ_TX_EMPTY] & q.irq_en[atx_pkg::IRQ_GLOBAL]
    & q.irq_en[atx_pkg::IRQ_PERIPHERAL];
  // pin is an output whenever the port is enabled, idle mark otherwise
  assign tx_clock_pin = q.line;
  assign tx_clock_pin_oe_n = ~q.rsc[atx_pkg::RSC_SERIAL_PORT_ENABLE];
endmodule
`default_nettype wire

// >>> core/atx_host.sv
/*
  controller end: axi4-lite slave whose words 0..7 pass through to the
  transmitter registers, plus a status word with the interrupt level.
  assumes: axi master on sys_clk; device end answers reads combinationally.
*/
`timescale 1ns/100ps
`default_nettype none
module atx_host (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [5:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [5:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  atx_if.host bus // transmitter register port
);
  typedef struct packed {
    logic aw_have; // write address held
    logic [5:0] waddr; // held write address
    logic w_have; // write data held
    logic [7:0] wdat; // held low byte
    logic wlane; // byte lane 0 enabled
    logic wr; // strobe to the device
    logic bvalid; // response pending
    logic [1:0] bresp; // write response code
    logic ar_have; // read address held
    logic [5:0] raddr; // held read address
    logic rvalid; // read data pending
    logic [1:0] rresp; // read response code
    logic [31:0] rdata; // read data
  } atx_host_state_t;

  atx_host_state_t q, d;

  // word index inside the device window
  function automatic logic in_window(logic [5:0] a);
    in_window = (a[5:2] <= atx_pkg::DEV_WINDOW_LAST);
  endfunction

  // accept channels, forward writes, answer reads
  always_comb begin
    d = q;
    d.wr = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_have = 1'b1;
      d.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_have = 1'b1;
      d.wdat = s_axi_wdata[7:0];
      d.wlane = s_axi_wstrb[0];
    end
    if (q.aw_have && q.w_have) begin
      // status word is read only; unmapped words answer slverr
      d.wr = in_window(q.waddr) & q.wlane;
      d.bvalid = 1'b1;
      d.bresp = (in_window(q.waddr) || q.waddr[5:2] == atx_pkg::HOST_STATUS_OFS[5:2])
        ? atx_pkg::RESP_OKAY : atx_pkg::RESP_SLVERR;
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      d.ar_have = 1'b1;
      d.raddr = s_axi_araddr;
    end
    // the shared address lines belong to a write strobe first
    if (q.ar_have && !q.wr) begin
      d.ar_have = 1'b0;
      d.rvalid = 1'b1;
      d.rresp = atx_pkg::RESP_OKAY;
      if (in_window(q.raddr)) begin
        d.rdata = {24'h000000, bus.rdata};
      end else if (q.raddr[5:2] == atx_pkg::HOST_STATUS_OFS[5:2]) begin
        d.rdata = 32'h00000000;
        d.rdata[atx_pkg::HOST_STAT_IRQ] = bus.irq;
      end else begin
        d.rdata = 32'h00000000;
        d.rresp = atx_pkg::RESP_SLVERR;
      end
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // one write and one read in flight at most
  assign s_axi_awready = ~q.aw_have & ~q.bvalid;
  assign s_axi_wready = ~q.w_have & ~q.bvalid;
  assign s_axi_arready = ~q.ar_have & ~q.rvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = q.rdata;
  assign bus.addr = q.wr ? q.waddr[4:2] : q.raddr[4:2];
  assign bus.wr = q.wr;
  assign bus.wdata = q.wdat;
endmodule
`default_nettype wire

// >>> verif/atx_chk_asserts.sv
/*
  concurrent checks on the register port and serial line of the transmitter.
  assumes: instantiated beside the interface; divisors stay 0 so no bit exceeds 64 clocks.
*/
`timescale 1ns/100ps
`default_nettype none
module atx_chk_asserts (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [2:0] addr, // register index
  input wire logic wr, // write strobe
  input wire logic [7:0] wdata, // write data
  input wire logic [7:0] rdata, // read data
  input wire logic irq, // interrupt request
  input wire logic tx_clock_pin, // serial line
  input wire logic tx_clock_pin_oe_n // pin enable, low drives
);
  logic te_q; // shadow transmit enable
  logic serial_port_enable_q; // shadow port enable
  logic irqen_q; // shadow: all three interrupt gates open
  logic [9:0] hi_q; // clocks at mark, saturating
  logic quiet; // mark longer than any run inside a frame, so nothing is in flight
  assign quiet = (hi_q == 10'h2c0);
  // rebuild only the control bits the properties need, from the write strobes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      te_q <= 1'b0;
      serial_port_enable_q <= 1'b0;
      irqen_q <= 1'b0;
      hi_q <= 10'h000;
    end else begin
      if (wr && addr == atx_pkg::OFS_TX_STATUS_CONTROL) begin
        te_q <= wdata[atx_pkg::TSC_TRANSMIT_ENABLE];
      end
      if (wr && addr == atx_pkg::OFS_RX_STATUS_CONTROL) begin
        serial_port_enable_q <= wdata[atx_pkg::RSC_SERIAL_PORT_ENABLE];
      end
      if (wr && addr == atx_pkg::OFS_IRQ_ENABLE) begin
        irqen_q <= wdata[7] & wdata[6] & wdata[4];
      end
      // saturate so a long idle never wraps back into looking busy
      if (!tx_clock_pin) begin
        hi_q <= 10'h000;
      end else if (hi_q != 10'h2c0) begin
        hi_q <= hi_q + 10'h001;
      end
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  AST_OE_ON: assert property (
    wr && addr == atx_pkg::OFS_RX_STATUS_CONTROL && wdata[7] |-> ##[1:2] !tx_clock_pin_oe_n)
    else $error("port enabled but pin not driven");
  AST_OE_OFF: assert property (
    wr && addr == atx_pkg::OFS_RX_STATUS_CONTROL && !wdata[7] |-> ##[1:2] tx_clock_pin_oe_n)
    else $error("port disabled but pin still driven");
  AST_IDLE_MARK: assert property (
    tx_clock_pin_oe_n && $past(tx_clock_pin_oe_n) |-> tx_clock_pin)
    else $error("line not at mark while port off");
  AST_START_AFTER_LOAD: assert property (
    wr && addr == atx_pkg::OFS_TRANSMIT_HOLDING && serial_port_enable_q && te_q && quiet
    |-> ##1 (!tx_clock_pin [*4]))
    else $error("idle load did not start a start bit");
  AST_SHIFT_EMPTY_MARK: assert property (
    addr == atx_pkg::OFS_TX_STATUS_CONTROL && rdata[atx_pkg::TSC_SHIFT_EMPTY] |-> tx_clock_pin)
    else $error("shift empty while line at space");
  AST_IRQ_TIE: assert property (
    addr == atx_pkg::OFS_IRQ_FLAG |-> irq == (rdata[atx_pkg::IRQ_TX_EMPTY] && irqen_q))
    else $error("irq differs from gated flag");
  AST_IRQ_GATED: assert property (irq |-> irqen_q)
    else $error("irq raised with a gate closed");
  AST_FLAG_LOW_BUSY: assert property (
    addr == atx_pkg::OFS_IRQ_FLAG && !rdata[atx_pkg::IRQ_TX_EMPTY] && te_q && $past(te_q)
    && $past(te_q, 2) |-> !quiet)
    else $error("flag low with nothing in flight");
  AST_FLAG_AFTER_ENABLE: assert property (
    wr && addr == atx_pkg::OFS_TX_STATUS_CONTROL && wdata[5] && serial_port_enable_q && irqen_q && quiet
    |-> ##[1:3] irq)
    else $error("enable did not raise the empty flag");
endmodule
`default_nettype wire

// >>> verif/test_async_serial_transmitter.sv
/*
  self-checking bench: axi4-lite master on the controller end, per-cycle
  watcher on the serial line, checker beside the register port.
  assumes: atx_pkg, atx_if, both design ends and the checker compile first.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); \
  end \
end
module test_async_serial_transmitter;
  localparam logic [1:0] OK = atx_pkg::RESP_OKAY; // normal response
  localparam logic [5:0] A_TSC = {1'b0, atx_pkg::OFS_TX_STATUS_CONTROL, 2'b00}; // control
  localparam logic [5:0] A_RSC = {1'b0, atx_pkg::OFS_RX_STATUS_CONTROL, 2'b00}; // port enable
  localparam logic [5:0] A_BDC = {1'b0, atx_pkg::OFS_BAUD_CONTROL, 2'b00}; // baud mode
  localparam logic [5:0] A_DVL = {1'b0, atx_pkg::OFS_BAUD_DIVISOR_LOW, 2'b00}; // divisor
  localparam logic [5:0] A_HLD = {1'b0, atx_pkg::OFS_TRANSMIT_HOLDING, 2'b00}; // holding
  localparam logic [5:0] A_IEN = {1'b0, atx_pkg::OFS_IRQ_ENABLE, 2'b00}; // irq gates
  localparam logic [5:0] A_FLG = {1'b0, atx_pkg::OFS_IRQ_FLAG, 2'b00}; // empty flag
  logic sys_clk = 1'b0; // system clock
  logic rst_n = 1'b0; // reset, active low
  logic [5:0] awaddr = 6'h00; // write address
  logic [5:0] araddr = 6'h00; // read address
  logic [31:0] wdata = 32'h00000000; // write data
  logic awvalid = 1'b0; // write address valid
  logic wvalid = 1'b0; // write data valid
  logic bready = 1'b0; // response ready
  logic arvalid = 1'b0; // read address valid
  logic rready = 1'b0; // read data ready
  logic awready, wready, bvalid, arready, rvalid; // slave handshakes
  logic [1:0] bresp, rresp; // responses
  logic [31:0] rdata; // read data
  logic tx_clock_pin, tx_clock_pin_oe_n; // serial line and its enable
  int err_count = 0; // mismatches
  int total_checks = 0; // comparisons made
  atx_if atx_if_inst ();
  atx_host atx_host_inst (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .bus(atx_if_inst.host));
  atx_dev atx_dev_inst (.sys_clk(sys_clk), .rst_n(rst_n), .bus(atx_if_inst.dev),
    .tx_clock_pin(tx_clock_pin), .tx_clock_pin_oe_n(tx_clock_pin_oe_n));
  atx_chk_asserts atx_chk_asserts_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .addr(atx_if_inst.addr), .wr(atx_if_inst.wr), .wdata(atx_if_inst.wdata),
    .rdata(atx_if_inst.rdata), .irq(atx_if_inst.irq), .tx_clock_pin(tx_clock_pin),
    .tx_clock_pin_oe_n(tx_clock_pin_oe_n));
  // 25 MHz clock
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  // report counts and the verdict, then stop
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // a wait that ran out counts as a mismatch and ends the run
  task automatic lost(input string what);
    err_count++;
    $display("ERROR %s timed out", what);
    tally_and_finish();
  endtask
  // readies are sampled at the falling edge; inputs only move after rising edges
  task automatic axi_wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ah, wh, bh;
    int n;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bh = 1'b0;
    for (n = 0; n < 100 && !bh; n++) begin
      @(negedge sys_clk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bvalid;
      if (bh) `CHK("bresp", er, bresp)
      @(posedge sys_clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
    end
    if (!bh) lost("write");
  endtask
  // read one word and compare it whole: bits 31:8 must read 0
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e, input logic [1:0] er,
    input string nm);
    logic ah, rh;
    int n;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rh = 1'b0;
    for (n = 0; n < 100 && !rh; n++) begin
      @(negedge sys_clk);
      ah = arvalid & arready;
      rh = rvalid;
      if (rh) `CHK("rresp", er, rresp)
      if (rh) `CHK(nm, {24'h000000, e}, rdata)
      @(posedge sys_clk);
      if (ah) arvalid <= 1'b0;
      if (rh) rready <= 1'b0;
    end
    if (!rh) lost("read");
  endtask
  // from the first space, every clock of nb bits of p clocks must match bits, lsb first
  task automatic watch(input logic [21:0] bits, input int nb, input int p, input string nm);
    int t, bad;
    bad = 0;
    for (t = 0; t < 4000 && tx_clock_pin !== 1'b0; t++) begin
      @(negedge sys_clk);
    end
    if (t == 4000) lost(nm);
    for (t = 0; t < nb * p; t++) begin
      if (tx_clock_pin !== bits[t / p]) bad++;
      @(negedge sys_clk);
    end
    `CHK(nm, 0, bad)
  endtask
  // long quiet start, then the window past the map is refused
  task automatic t_reset();
    repeat (720) @(posedge sys_clk);
    `CHK("idle line", 1'b1, tx_clock_pin)
    `CHK("pin undriven", 1'b1, tx_clock_pin_oe_n)
    rd_chk(A_FLG, 8'h00, OK, "flag off");
    rd_chk(6'h24, 8'h00, atx_pkg::RESP_SLVERR, "unmapped");
    axi_wr(6'h24, 8'hff, atx_pkg::RESP_SLVERR);
  endtask
  // setup in order; flag and interrupt follow enables, flag ignores writes and masks
  task automatic t_enable();
    axi_wr(A_RSC, 8'h80, OK);
    repeat (2) @(negedge sys_clk);
    `CHK("pin driven", 1'b0, tx_clock_pin_oe_n)
    axi_wr(A_BDC, 8'h08, OK);
    axi_wr(A_DVL, 8'h00, OK);
    axi_wr(A_IEN, 8'hd0, OK);
    axi_wr(A_TSC, 8'h24, OK);
    rd_chk(A_FLG, 8'h10, OK, "flag on enable");
    rd_chk(atx_pkg::HOST_STATUS_OFS, 8'h01, OK, "irq");
    rd_chk(A_TSC, 8'h26, OK, "shift empty idle");
    axi_wr(A_FLG, 8'h00, OK);
    rd_chk(A_FLG, 8'h10, OK, "flag kept");
    axi_wr(A_IEN, 8'h00, OK);
    rd_chk(atx_pkg::HOST_STATUS_OFS, 8'h00, OK, "irq masked");
    rd_chk(A_FLG, 8'h10, OK, "flag unmasked");
  endtask
  // two writes back to back at 4 clocks a bit: second waits, then follows the stop at once
  task automatic t_pair();
    fork
      watch({2'b00, 1'b1, 8'h3c, 1'b0, 1'b1, 8'ha5, 1'b0}, 20, 4, "two frames");
      begin
        axi_wr(A_HLD, 8'ha5, OK);
        axi_wr(A_HLD, 8'h3c, OK);
        rd_chk(A_FLG, 8'h00, OK, "flag queued");
        rd_chk(A_TSC, 8'h24, OK, "shift busy");
      end
    join
    rd_chk(A_FLG, 8'h10, OK, "flag drained");
    rd_chk(A_TSC, 8'h26, OK, "shift drained");
  endtask
  // nine data bits, ninth written first, both values of the address mark
  task automatic t_nine();
    logic [7:0] d;
    int i;
    for (i = 0; i < 2; i++) begin
      d = (i == 0) ? 8'hc3 : 8'h3c;
      axi_wr(A_TSC, {7'h32, i[0]}, OK);
      fork
        watch({11'h000, 1'b1, i[0], d, 1'b0}, 11, 4, "nine bit frame");
        axi_wr(A_HLD, d, OK);
      join
    end
  endtask
  // normal speed, 64 clocks a bit, lsb first with a space in bit 0
  task automatic t_slow();
    axi_wr(A_BDC, 8'h00, OK);
    axi_wr(A_TSC, 8'h20, OK);
    fork
      watch({12'h000, 1'b1, 8'h5a, 1'b0}, 10, 64, "slow frame");
      axi_wr(A_HLD, 8'h5a, OK);
    join
  endtask
  // port off mid frame empties everything; later loads are dropped
  task automatic t_abort();
    axi_wr(A_HLD, 8'hff, OK);
    axi_wr(A_HLD, 8'h81, OK);
    axi_wr(A_RSC, 8'h00, OK);
    rd_chk(A_TSC, 8'h22, OK, "shift emptied");
    rd_chk(A_FLG, 8'h10, OK, "holding emptied");
    `CHK("line idled", 1'b1, tx_clock_pin)
    `CHK("pin released", 1'b1, tx_clock_pin_oe_n)
    axi_wr(A_HLD, 8'h00, OK);
    repeat (70) @(negedge sys_clk);
    `CHK("no frame when off", 1'b1, tx_clock_pin)
    rd_chk(A_TSC, 8'h22, OK, "still empty");
    axi_wr(A_RSC, 8'h80, OK);
    axi_wr(A_TSC, 8'h30, OK);
    axi_wr(A_HLD, 8'h00, OK);
    rd_chk(A_TSC, 8'h32, OK, "clocked mode drops");
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_enable();
    t_pair();
    t_nine();
    t_slow();
    t_abort();
    tally_and_finish();
  end
endmodule
`default_nettype wire
